// File: shared/pcr_pkg.sv
// shared constants and types for the parameter-read sequence interpreter
package pcr_pkg;
  localparam logic [11:0] SEQ_PERIOD = 12'h010;
  localparam logic [11:0] SEQ_RAMP = 12'h011;
  localparam logic [11:0] SEQ_LOOPBRK = 12'h012;
  localparam logic [11:0] SEQ_FALLBACK = 12'h013;
  localparam logic [11:0] SEQ_LIMITS = 12'h014;
  localparam logic [11:0] SEQ_FILTER = 12'h015;
  localparam logic [11:0] SEQ_ALMHYS = 12'h016;
  localparam logic [15:0] SEND_COUNT = 16'h0002;
  localparam logic [7:0] UNIT_MAX = 8'h31;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [15:0] RX_COUNT_2 = 16'h0002;
  localparam logic [15:0] RX_COUNT_3 = 16'h0003;
  localparam logic [15:0] RX_COUNT_4 = 16'h0004;
  localparam logic [1:0] LAST_2 = 2'h1;
  localparam logic [1:0] LAST_3 = 2'h2;
  localparam logic [1:0] LAST_4 = 2'h3;
  localparam logic [3:0] SIGN_F = 4'hf;
  localparam logic [3:0] SIGN_A = 4'ha;
  localparam logic signed [15:0] V_ZERO = 16'sh0000;
  localparam logic signed [15:0] V_ONE = 16'sh0001;
  localparam logic signed [15:0] V_PERIOD_MAX = 16'sh0063;
  localparam logic signed [15:0] V_MAX = 16'sh270f;
  localparam logic signed [15:0] V_MV_MIN = -16'sh0032;
  localparam logic signed [15:0] V_MV_MAX = 16'sh041a;
  localparam logic signed [15:0] V_RATE_MAX = 16'sh03e8;
  localparam int BIN_W = 14;
  localparam int DIGITS = 4;
  localparam logic [3:0] DD_LIMIT = 4'h4;
  localparam logic [3:0] DD_ADJ = 4'h3;
  localparam int WORDS = 4;
  typedef struct packed {
    logic [15:0] send_count;
    logic [15:0] send_unit;
    logic [11:0] seq;
  } pcr_req_t;
  typedef logic signed [2:0][15:0] pcr_ans_t;
  typedef struct packed {
    logic signed [15:0] lo;
    logic signed [15:0] hi;
  } pcr_rng_t;
endpackage

// File: core/pcr_mem.sv
// small receive-word buffer with registered read data
`timescale 1ns/10ps
module pcr_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] raddr,
  output logic [15:0] rdata
);
  import pcr_pkg::*;
  logic [WORDS-1:0][15:0] mem_r;
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule

// File: core/pcr_core.sv
// parameter-read sequence interpreter, sequences 010 to 016
`timescale 1ns/10ps
// How it works
// (R1) caller puts send count 0002 first
// (R2) unit number BCD 00-31, upper byte ignored
// (R3) first receive word is total word count
// (R4) 010: count 0003, two periods 0001-0099
// (R5) 011: ramp unit 0000 s, 0001 hr
// (R6) 011: ramp set value 0000-9999
// (R7) 012: count 0002, loop-break time 0000-9999
// (R8) 013: count 0003, stop then error output
// (R9) fallback outputs F050-1050, F marks negative
// (R10) heat/cool: stop and lower use A sign
// (R11) 014: count 0004, upper, lower, rate limits
// (R12) upper limit up to 1050, heat/cool from 0000
// (R13) lower limit F050 to upper minus one (1049); heat/cool lets it reach 1050
// (R14) 014: change-rate limit 0000-1000
// (R15) 015: count 0002, input filter 0000-9999
// (R16) 016: count 0003, two hysteresis 0001-9999
// (R17) caller names send and receive areas
// (R18) bad count or unit rejected, nothing written
module pcr_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire pcr_pkg::pcr_req_t req,
  input wire logic heat_cool,
  input wire logic unit_ack,
  input wire pcr_pkg::pcr_ans_t unit_words,
  output logic busy,
  output logic unit_req,
  output logic [7:0] unit_no,
  output logic [11:0] unit_seq,
  output logic rx_wr,
  output logic [1:0] rx_idx,
  output logic [15:0] rx_data,
  output logic done,
  output logic reject
);
  import pcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_QUERY, ST_FILL, ST_DRAIN, ST_FLUSH} pcr_state_t;
  typedef struct packed {
    pcr_state_t st;
    logic [11:0] seq;
    logic [7:0] unit;
    logic heat_cool;
    pcr_ans_t words;
    logic [1:0] last;
    logic [1:0] idx;
    logic pend;
    logic [1:0] pend_i;
    logic busy;
    logic unit_req;
    logic rx_wr;
    logic [1:0] rx_idx;
    logic [15:0] rx_data;
    logic done;
    logic reject;
  } pcr_regs_t;

  pcr_regs_t st_r;
  pcr_regs_t st_nxt;
  logic mem_we;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic bcd_ok(input logic [7:0] b);
    return b[7:4] <= BCD_DIGIT_MAX && b[3:0] <= BCD_DIGIT_MAX;
  endfunction

  function automatic logic seq_ok(input logic [11:0] s);
    return s >= SEQ_PERIOD && s <= SEQ_ALMHYS;
  endfunction

  function automatic logic [15:0] rx_count(input logic [11:0] s);
    case (s)
      SEQ_LOOPBRK, SEQ_FILTER: return RX_COUNT_2; // (R7) (R15)
      SEQ_LIMITS: return RX_COUNT_4; // (R11)
      default: return RX_COUNT_3; // (R4) (R8) (R16)
    endcase
  endfunction

  function automatic logic [1:0] last_idx(input logic [11:0] s);
    case (s)
      SEQ_LOOPBRK, SEQ_FILTER: return LAST_2;
      SEQ_LIMITS: return LAST_4;
      default: return LAST_3;
    endcase
  endfunction

  function automatic pcr_rng_t range_of(input logic [11:0] s,
                                        input logic [1:0] w,
                                        input logic hc);
    pcr_rng_t r;
    r.lo = V_ZERO;
    r.hi = V_MAX;
    case (s)
      SEQ_PERIOD: begin
        r.lo = V_ONE; // (R4)
        r.hi = V_PERIOD_MAX;
      end
      SEQ_RAMP: begin
        if (w == LAST_2) begin
          r.hi = V_ONE; // (R5)
        end
      end
      SEQ_FALLBACK: begin
        r.lo = V_MV_MIN; // (R9)
        r.hi = V_MV_MAX;
      end
      SEQ_LIMITS: begin
        if (w == LAST_2) begin
          r.lo = hc ? V_ZERO : V_MV_MIN + V_ONE; // (R12)
          r.hi = V_MV_MAX;
        end else if (w == LAST_3) begin
          r.lo = V_MV_MIN; // (R13)
          r.hi = hc ? V_MV_MAX : V_MV_MAX - V_ONE;
        end else begin
          r.hi = V_RATE_MAX; // (R14)
        end
      end
      SEQ_ALMHYS: r.lo = V_ONE; // (R16)
      default: r.lo = V_ZERO; // (R6) (R7) (R15)
    endcase
    return r;
  endfunction

  function automatic logic [15:0] to_bcd(input logic [BIN_W-1:0] b);
    logic [4*DIGITS+BIN_W-1:0] s;
    s = {{(4*DIGITS){1'b0}}, b};
    for (int k = 0; k < BIN_W; k++) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (s[BIN_W+4*d +: 4] > DD_LIMIT) begin
          s[BIN_W+4*d +: 4] = s[BIN_W+4*d +: 4] + DD_ADJ;
        end
      end
      s = s << 1;
    end
    return s[4*DIGITS+BIN_W-1:BIN_W];
  endfunction

  function automatic logic [15:0] encode(input logic signed [15:0] v,
                                         input logic [11:0] s,
                                         input logic [1:0] w,
                                         input logic hc);
    pcr_rng_t r;
    logic signed [15:0] c;
    logic [15:0] mag;
    logic [15:0] b;
    logic a_sign;
    r = range_of(s, w, hc);
    c = (v < r.lo) ? r.lo : ((v > r.hi) ? r.hi : v);
    mag = c[15] ? 16'(-c) : 16'(c);
    b = to_bcd(mag[BIN_W-1:0]);
    a_sign = hc && ((s == SEQ_FALLBACK && w == LAST_2) ||
                    (s == SEQ_LIMITS && w == LAST_3)); // (R10)
    if (c[15]) begin
      b[15:12] = a_sign ? SIGN_A : SIGN_F; // (R9) (R13)
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.unit_req = 1'b0;
    st_nxt.rx_wr = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.reject = 1'b0;
    st_nxt.pend = 1'b0;
    mem_we = 1'b0;
    mem_wdata = rx_count(st_r.seq);
    case (st_r.st)
      ST_IDLE: begin
        if (req_valid) begin
          if (req.send_count == SEND_COUNT && seq_ok(req.seq) &&
              bcd_ok(req.send_unit[7:0]) &&
              req.send_unit[7:0] <= UNIT_MAX) begin // (R1) (R2)
            st_nxt.st = ST_QUERY;
            st_nxt.seq = req.seq;
            st_nxt.unit = req.send_unit[7:0];
            st_nxt.heat_cool = heat_cool;
            st_nxt.last = last_idx(req.seq);
            st_nxt.busy = 1'b1;
            st_nxt.unit_req = 1'b1;
          end else begin
            st_nxt.reject = 1'b1; // (R18)
          end
        end
      end
      ST_QUERY: begin
        st_nxt.unit_req = ~unit_ack;
        if (unit_ack) begin
          st_nxt.words = unit_words;
          st_nxt.idx = '0;
          st_nxt.st = ST_FILL;
        end
      end
      ST_FILL: begin
        mem_we = 1'b1;
        if (st_r.idx != '0) begin
          mem_wdata = encode(st_r.words[st_r.idx - 2'h1], st_r.seq,
                             st_r.idx, st_r.heat_cool); // (R3)
        end
        st_nxt.idx = st_r.idx + 2'h1;
        if (st_r.idx == st_r.last) begin
          st_nxt.idx = '0;
          st_nxt.st = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        st_nxt.pend = 1'b1;
        st_nxt.pend_i = st_r.idx;
        st_nxt.idx = st_r.idx + 2'h1;
        if (st_r.idx == st_r.last) begin
          st_nxt.st = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        st_nxt.st = ST_IDLE;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
      default: st_nxt.st = ST_IDLE;
    endcase
    if (st_r.pend) begin
      st_nxt.rx_wr = 1'b1; // (R3)
      st_nxt.rx_idx = st_r.pend_i;
      st_nxt.rx_data = mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.st <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pcr_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(st_r.idx),
    .wdata(mem_wdata),
    .raddr(st_r.idx),
    .rdata(mem_rdata)
  );

  assign busy = st_r.busy;
  assign unit_req = st_r.unit_req;
  assign unit_no = st_r.unit;
  assign unit_seq = st_r.seq;
  assign rx_wr = st_r.rx_wr;
  assign rx_idx = st_r.rx_idx;
  assign rx_data = st_r.rx_data;
  assign done = st_r.done;
  assign reject = st_r.reject;
endmodule

// File: dv/pcr_core_monitor.sv
// assertion checker for the parameter-read interpreter
`timescale 1ns/10ps
module pcr_core_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic busy,
  input wire logic unit_req,
  input wire logic unit_ack,
  input wire logic [11:0] unit_seq,
  input wire logic rx_wr,
  input wire logic [1:0] rx_idx,
  input wire logic done,
  input wire logic reject
);
  import pcr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  take_or_refuse_a: assert property (
    req_valid && !busy |=> unit_req ^ reject) else $error("not taken");
  refuse_quiet_a: assert property (
    reject |-> !rx_wr && !unit_req) else $error("refused but active");
  first_word_a: assert property (
    unit_ack && unit_seq != SEQ_LOOPBRK && unit_seq != SEQ_FILTER &&
    unit_seq != SEQ_LIMITS |-> ##6 rx_wr && rx_idx == 2'h0)
    else $error("late count");
  short_first_word_a: assert property (
    unit_ack && (unit_seq == SEQ_LOOPBRK || unit_seq == SEQ_FILTER) |->
    ##5 rx_wr && rx_idx == 2'h0) else $error("late count, two words");
  long_first_word_a: assert property (
    unit_ack && unit_seq == SEQ_LIMITS |-> ##7 rx_wr && rx_idx == 2'h0)
    else $error("late count, four words");
  ack_release_a: assert property (
    unit_ack |=> !unit_req) else $error("request held");
  word_order_a: assert property (
    rx_wr && rx_idx != 2'h0 |-> $past(rx_wr) &&
    rx_idx == $past(rx_idx) + 2'h1) else $error("word order");
  last_word_a: assert property (
    done |-> rx_wr && rx_idx != 2'h0 && !busy) else $error("bad done");
  done_single_a: assert property (
    done |=> !done && !rx_wr) else $error("done too long");
  write_quiet_a: assert property (
    rx_wr |-> !unit_req) else $error("write while asking");
endmodule
bind pcr_core pcr_core_monitor i_pcr_core_monitor (.clk, .rst,
  .req_valid, .busy, .unit_req, .unit_ack, .unit_seq, .rx_wr, .rx_idx,
  .done, .reject);

// File: dv/pcr_unit_model.sv
// model of the addressed controller unit answering a read
`timescale 1ns/10ps
module pcr_unit_model (
  input wire logic clk,
  input wire logic unit_req,
  input wire logic [3:0] delay,
  input wire pcr_pkg::pcr_ans_t words,
  output logic unit_ack,
  output pcr_pkg::pcr_ans_t unit_words
);
  import pcr_pkg::*;
  logic [3:0] cnt_r = 4'h0;
  initial unit_ack = 1'b0;
  always @(posedge clk) begin
    if (!unit_req || unit_ack) begin
      cnt_r <= 4'h0;
      unit_ack <= 1'b0;
    end else if (cnt_r == delay) begin
      unit_ack <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // words only valid with the answer pulse
  assign unit_words = unit_ack ? words : ~words;
endmodule

// File: dv/tb_pcr_core.sv
// testbench for the parameter-read interpreter
`timescale 1ns/10ps
module tb_pcr_core;
  import pcr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  pcr_req_t req = '0;
  logic heat_cool = 1'b0;
  logic [3:0] delay = 4'h0;
  pcr_ans_t wv = '0;
  logic unit_ack, busy, unit_req, rx_wr, done, reject;
  pcr_ans_t unit_words;
  logic [7:0] unit_no;
  logic [11:0] unit_seq;
  logic [1:0] rx_idx;
  logic [15:0] rx_data;
  logic [15:0] cnt = SEND_COUNT;
  logic [15:0] unit = 16'hab31;
  int n_fail = 0;
  int compares = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  pcr_core i_pcr_core (.clk, .rst, .req_valid, .req, .heat_cool,
    .unit_ack, .unit_words, .busy, .unit_req, .unit_no, .unit_seq,
    .rx_wr, .rx_idx, .rx_data, .done, .reject);
  pcr_unit_model i_pcr_unit_model (.clk, .unit_req, .delay,
    .words(wv), .unit_ack, .unit_words);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t(input logic [11:0] s, input logic h,
    input logic [3:0] d, input int n, w0, w1, w2,
    input logic [15:0] e1, e2, e3);
    logic [15:0] ex [4];
    int k;
    int i;
    ex = '{16'(n), e1, e2, e3};
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{send_count: cnt, send_unit: unit, seq: s};
    heat_cool <= h;
    delay <= d;
    wv <= '{w2[15:0], w1[15:0], w0[15:0]};
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (rx_wr === 1'b1) begin
        chk(rx_idx === 2'(k) && rx_data === ex[k], "receive word");
        k++;
      end
      if (done === 1'b1 || reject === 1'b1) break;
      @(posedge clk);
    end
    if (i == 40) begin
      chk(1'b0, "timeout");
      give_verdict();
    end
    chk(k == n && reject === (n == 0), "word count or refusal");
    if (n > 0) chk(unit_no === unit[7:0] && unit_seq === s, "unit");
    $display("test seq %h done", s);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t(SEQ_PERIOD,0,0,3,1,99,0,16'h0001,16'h0099,16'h0);
    t(SEQ_RAMP,0,3,3,1,9999,0,16'h0001,16'h9999,16'h0);
    t(SEQ_RAMP,0,0,3,0,0,0,16'h0000,16'h0000,16'h0);
    t(SEQ_LOOPBRK,0,1,2,9999,0,0,16'h9999,16'h0,16'h0);
    t(SEQ_FALLBACK,0,0,3,-50,1050,0,16'hf050,16'h1050,16'h0);
    t(SEQ_FALLBACK,1,2,3,-50,-50,0,16'ha050,16'hf050,16'h0);
    t(SEQ_LIMITS,0,0,4,1050,-50,1000,16'h1050,16'hf050,16'h1000);
    t(SEQ_LIMITS,1,5,4,0,-50,0,16'h0000,16'ha050,16'h0000);
    unit = 16'hff00;
    t(SEQ_FILTER,0,7,2,1234,0,0,16'h1234,16'h0,16'h0);
    t(SEQ_ALMHYS,0,0,3,1,9999,0,16'h0001,16'h9999,16'h0);
    cnt = 16'h0003;
    t(SEQ_FILTER,0,0,0,0,0,0,16'h0,16'h0,16'h0);
    cnt = SEND_COUNT;
    unit = 16'h0032;
    t(SEQ_FILTER,0,0,0,0,0,0,16'h0,16'h0,16'h0);
    unit = 16'h001a;
    t(SEQ_PERIOD,0,0,0,0,0,0,16'h0,16'h0,16'h0);
    unit = 16'h0031;
    t(12'h017,0,0,0,0,0,0,16'h0,16'h0,16'h0);
    t(SEQ_LIMITS,0,0,4,1049,-49,0,16'h1049,16'hf049,16'h0);
    t(SEQ_LIMITS,0,0,4,-50,1050,1001,16'hf049,16'h1049,16'h1000);
    t(SEQ_PERIOD,0,0,3,0,100,0,16'h0001,16'h0099,16'h0);
    give_verdict();
  end
endmodule
